// >>> loop_ch1_event_defs.svh
`ifndef LOOP_CH1_EVENT_DEFS_SVH
`define LOOP_CH1_EVENT_DEFS_SVH

// ----------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------
`define CH1_LOCK_EVENT_OFFSET     16'h3015
`define CH1_STATE_EVENT_OFFSET    16'h3016
`define CH1_ACQ_EVENT_OFFSET      16'h3017
`define CH1_PROFILE_EVENT_OFFSET  16'h3018
`define CH1_ANALOG_EVENT_OFFSET   16'h3019

// ----------------------------------------------------------------------
// reset and read values
// ----------------------------------------------------------------------
`define EVENT_FLAGS_RESET         8'h00
`define UNMAPPED_READ_VALUE       8'h00
`define IDLE_READ_VALUE           8'h00

// ----------------------------------------------------------------------
// lock event field positions
// ----------------------------------------------------------------------
`define LOCK_CLAMP_OFF_BIT        7
`define LOCK_CLAMP_ON_BIT         6
`define LOCK_SLEW_OFF_BIT         5
`define LOCK_SLEW_ON_BIT          4
`define LOCK_FREQ_UNLOCK_BIT      3
`define LOCK_FREQ_LOCK_BIT        2
`define LOCK_PHASE_UNLOCK_BIT     1
`define LOCK_PHASE_LOCK_BIT       0

// ----------------------------------------------------------------------
// state event field positions
// ----------------------------------------------------------------------
`define STATE_REF_SWITCH_BIT      7
`define STATE_FREERUN_BIT         6
`define STATE_HOLDOVER_BIT        5
`define STATE_HITLESS_IN_BIT      4
`define STATE_HITLESS_OUT_BIT     3
`define STATE_HISTORY_BIT         2
`define STATE_PHASE_STEP_BIT      0

// ----------------------------------------------------------------------
// acquisition, profile and analog loop field positions
// ----------------------------------------------------------------------
`define ACQ_NDIV_RESYNC_BIT       4
`define ACQ_DONE_BIT              3
`define ACQ_START_BIT             2
`define PROFILE_COUNT             6
`define ANALOG_DIST_SYNC_BIT      4
`define ANALOG_UNLOCK_BIT         3
`define ANALOG_LOCK_BIT           2
`define ANALOG_CAL_DONE_BIT       1
`define ANALOG_CAL_START_BIT      0

// ----------------------------------------------------------------------
// level vector layout fed to the edge detector
// ----------------------------------------------------------------------
`define LVL_WIDTH                 16
`define LVL_FREQ_LOCK             0
`define LVL_PHASE_LOCK            1
`define LVL_CLAMP                 2
`define LVL_SLEW                  3
`define LVL_HITLESS               4
`define LVL_FAST_ACQ              5
`define LVL_ANALOG_LOCK           6
`define LVL_CAL_BUSY              7
`define LVL_FREERUN               8
`define LVL_HOLDOVER              9
`define LVL_PROFILE_BASE          10

`endif

// >>> loop_ch1_event_pkg.sv
package loop_ch1_event_pkg;

    typedef enum logic [1:0] {
        mode_freerun,
        mode_holdover,
        mode_active
    } loop_mode_e;

    // live condition of the loop, sampled every clock
    typedef struct packed {
        logic       freq_locked;
        logic       phase_locked;
        logic       clamp_active;
        logic       slew_limit_active;
        logic       hitless;
        logic       fast_acq_active;
        logic       analog_locked;
        logic       analog_cal_busy;
        loop_mode_e mode;
        logic [1:0] ref_select;
        logic       profile_valid;
        logic [2:0] active_profile;
    } loop_status_s;

    // one-cycle events raised by the loop itself
    typedef struct packed {
        logic history_update;
        logic phase_step;
        logic ndiv_resync;
        logic dist_sync;
    } loop_pulse_s;

    typedef struct packed {
        logic [15:0] addr;
        logic [7:0]  wdata;
        logic        wr;
        logic        rd;
    } reg_req_s;

    typedef struct packed {
        logic [7:0] lock_flags;
        logic [7:0] state_flags;
        logic [7:0] acq_flags;
        logic [7:0] profile_flags;
        logic [7:0] analog_flags;
    } event_flags_s;

endpackage : loop_ch1_event_pkg

// >>> level_edge_detect.sv
`timescale 1ns/10ps
`include "loop_ch1_event_defs.svh"

module level_edge_detect #(
    parameter int W = `LVL_WIDTH
) (
    input  wire logic         clock,
    input  wire logic         arst_n,
    input  wire logic [W-1:0] level,
    output logic      [W-1:0] rise,
    output logic      [W-1:0] fall
);

    typedef struct packed {
        logic         primed;
        logic [W-1:0] last;
    } edge_state_s;

    edge_state_s state;
    edge_state_s next_state;

    // --------------------------------------------------------------
    // edge detection
    // --------------------------------------------------------------
    // the first sample after reset only primes the history, so a loop
    // already locked at reset release does not report a false lock
    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_bit
            assign rise[i] = state.primed & level[i] & ~state.last[i];
            assign fall[i] = state.primed & ~level[i] & state.last[i];
        end
    endgenerate

    always_comb begin
        next_state        = state;
        next_state.primed = 1'b1;
        next_state.last   = level;
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

endmodule : level_edge_detect

// >>> event_reg_port.sv
`timescale 1ns/10ps
`include "loop_ch1_event_defs.svh"

module event_reg_port (
    input  wire logic                         clock,
    input  wire logic                         arst_n,
    input  wire loop_ch1_event_pkg::reg_req_s req,
    input  wire loop_ch1_event_pkg::event_flags_s flags,
    output logic [7:0]                        rdata
);

    typedef struct packed {
        logic [7:0] rdata;
    } port_state_s;

    port_state_s state;
    port_state_s next_state;

    // --------------------------------------------------------------
    // read decode
    // --------------------------------------------------------------
    // read data stands only in the cycle after the strobe; writes are
    // never looked at, the whole bank is read only
    always_comb begin
        next_state       = state;
        next_state.rdata = `IDLE_READ_VALUE;
        if (req.rd) begin
            unique case (req.addr)
                `CH1_LOCK_EVENT_OFFSET:    next_state.rdata = flags.lock_flags;
                `CH1_STATE_EVENT_OFFSET:   next_state.rdata = flags.state_flags;
                `CH1_ACQ_EVENT_OFFSET:     next_state.rdata = flags.acq_flags;
                `CH1_PROFILE_EVENT_OFFSET: next_state.rdata = flags.profile_flags;
                `CH1_ANALOG_EVENT_OFFSET:  next_state.rdata = flags.analog_flags;
                default:                   next_state.rdata = `UNMAPPED_READ_VALUE;
            endcase
        end
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign rdata = state.rdata;

endmodule : event_reg_port

// >>> loop_ch1_irq_status_bank.sv
// The implementer's own choice: the strobed register port.
`timescale 1ns/10ps
`include "loop_ch1_event_defs.svh"

// Overview of operation
// - lock reg bits 7/6: clamp off/on
// - lock reg bits 5/4: slew limiter off/on
// - bits 3/2: frequency detector unlock/lock
// - bits 1/0: phase detector unlock/lock
// - state reg bit 7: reference switched
// - state bits 6/5: freerun/holdover entered
// - state bits 4/3: hitless entered/exited
// - state bit 2: holdover history updated
// - state bit 0 phase step; bit 1 reserved
// - acq reg bit 4 N-divider resync; bits 7..5 and 1..0 reserved
// - acq bits 3/2: fast acquisition done/started
// - profile reg bits 5..0: profile activated
// - analog reg bit 4: distribution synced
// - analog bits 3..0: unlock, lock, cal done/start
module loop_ch1_irq_status_bank (
    input  wire logic                             clock,
    input  wire logic                             arst_n,
    input  wire loop_ch1_event_pkg::loop_status_s status,
    input  wire loop_ch1_event_pkg::loop_pulse_s  pulse,
    input  wire logic [15:0]                      addr,
    input  wire logic [7:0]                       wdata,
    input  wire logic                             wr,
    input  wire logic                             rd,
    output logic [7:0]                            rdata
);

    // --------------------------------------------------------------
    // state
    // --------------------------------------------------------------
    typedef struct packed {
        logic                             primed;
        logic [1:0]                       last_ref;
        loop_ch1_event_pkg::event_flags_s flags;
    } bank_state_s;

    bank_state_s state;
    bank_state_s next_state;

    logic [`LVL_WIDTH-1:0]     level;
    logic [`LVL_WIDTH-1:0]     rise;
    logic [`LVL_WIDTH-1:0]     fall;
    logic [`PROFILE_COUNT-1:0] profile_onehot;
    logic                      ref_switched;

    loop_ch1_event_pkg::event_flags_s event_set;
    loop_ch1_event_pkg::reg_req_s     req;

    // --------------------------------------------------------------
    // level vector for the edge detector
    // --------------------------------------------------------------
    genvar p;
    generate
        for (p = 0; p < `PROFILE_COUNT; p++) begin : g_profile
            assign profile_onehot[p] = status.profile_valid &
                (status.active_profile == 3'(p));
        end
    endgenerate

    assign level[`LVL_FREQ_LOCK]   = status.freq_locked;
    assign level[`LVL_PHASE_LOCK]  = status.phase_locked;
    assign level[`LVL_CLAMP]       = status.clamp_active;
    assign level[`LVL_SLEW]        = status.slew_limit_active;
    assign level[`LVL_HITLESS]     = status.hitless;
    assign level[`LVL_FAST_ACQ]    = status.fast_acq_active;
    assign level[`LVL_ANALOG_LOCK] = status.analog_locked;
    assign level[`LVL_CAL_BUSY]    = status.analog_cal_busy;
    assign level[`LVL_FREERUN]     = (status.mode == loop_ch1_event_pkg::mode_freerun);
    assign level[`LVL_HOLDOVER]    = (status.mode == loop_ch1_event_pkg::mode_holdover);
    assign level[`LVL_PROFILE_BASE +: `PROFILE_COUNT] = profile_onehot;

    level_edge_detect #(
        .W (`LVL_WIDTH)
    ) u_edges (
        .clock  (clock),
        .arst_n (arst_n),
        .level  (level),
        .rise   (rise),
        .fall   (fall)
    );

    // --------------------------------------------------------------
    // lock events
    // --------------------------------------------------------------
    always_comb begin
        event_set.lock_flags = '0;
        event_set.lock_flags[`LOCK_CLAMP_OFF_BIT]    = fall[`LVL_CLAMP];
        event_set.lock_flags[`LOCK_CLAMP_ON_BIT]     = rise[`LVL_CLAMP];
        event_set.lock_flags[`LOCK_SLEW_OFF_BIT]     = fall[`LVL_SLEW];
        event_set.lock_flags[`LOCK_SLEW_ON_BIT]      = rise[`LVL_SLEW];
        event_set.lock_flags[`LOCK_FREQ_UNLOCK_BIT]  = fall[`LVL_FREQ_LOCK];
        event_set.lock_flags[`LOCK_FREQ_LOCK_BIT]    = rise[`LVL_FREQ_LOCK];
        event_set.lock_flags[`LOCK_PHASE_UNLOCK_BIT] = fall[`LVL_PHASE_LOCK];
        event_set.lock_flags[`LOCK_PHASE_LOCK_BIT]   = rise[`LVL_PHASE_LOCK];
    end

    // --------------------------------------------------------------
    // state events
    // --------------------------------------------------------------
    // a reference change is only meaningful once a previous selection
    // has been seen, hence the primed qualifier
    // reference change detect
    assign ref_switched = state.primed & (status.ref_select != state.last_ref);

    always_comb begin
        event_set.state_flags = '0;
        event_set.state_flags[`STATE_REF_SWITCH_BIT]  = ref_switched;
        event_set.state_flags[`STATE_FREERUN_BIT]     = rise[`LVL_FREERUN];
        event_set.state_flags[`STATE_HOLDOVER_BIT]    = rise[`LVL_HOLDOVER];
        event_set.state_flags[`STATE_HITLESS_IN_BIT]  = rise[`LVL_HITLESS];
        event_set.state_flags[`STATE_HITLESS_OUT_BIT] = fall[`LVL_HITLESS];
        event_set.state_flags[`STATE_HISTORY_BIT]     = pulse.history_update;
        // phase step, bit 1 left zero
        event_set.state_flags[`STATE_PHASE_STEP_BIT]  = pulse.phase_step;
    end

    // --------------------------------------------------------------
    // acquisition and profile events
    // --------------------------------------------------------------
    always_comb begin
        event_set.acq_flags = '0;
        event_set.acq_flags[`ACQ_NDIV_RESYNC_BIT] = pulse.ndiv_resync;
        event_set.acq_flags[`ACQ_DONE_BIT]        = fall[`LVL_FAST_ACQ];
        event_set.acq_flags[`ACQ_START_BIT]       = rise[`LVL_FAST_ACQ];
    end

    always_comb begin
        event_set.profile_flags = '0;
        event_set.profile_flags[`PROFILE_COUNT-1:0] =
            rise[`LVL_PROFILE_BASE +: `PROFILE_COUNT];
    end

    // --------------------------------------------------------------
    // analog loop events
    // --------------------------------------------------------------
    always_comb begin
        event_set.analog_flags = '0;
        event_set.analog_flags[`ANALOG_DIST_SYNC_BIT] = pulse.dist_sync;
        event_set.analog_flags[`ANALOG_UNLOCK_BIT]    = fall[`LVL_ANALOG_LOCK];
        event_set.analog_flags[`ANALOG_LOCK_BIT]      = rise[`LVL_ANALOG_LOCK];
        event_set.analog_flags[`ANALOG_CAL_DONE_BIT]  = fall[`LVL_CAL_BUSY];
        event_set.analog_flags[`ANALOG_CAL_START_BIT] = rise[`LVL_CAL_BUSY];
    end

    // --------------------------------------------------------------
    // sticky flags
    // --------------------------------------------------------------
    // no clear path exists in this bank; flags hold until reset.
    // wr and wdata are accepted but deliberately never steer state.
    always_comb begin
        next_state          = state;
        next_state.primed   = 1'b1;
        next_state.last_ref = status.ref_select;
        next_state.flags    = state.flags | event_set;
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            state.primed              <= 1'b0;
            state.last_ref            <= 2'h0;
            state.flags.lock_flags    <= `EVENT_FLAGS_RESET;
            state.flags.state_flags   <= `EVENT_FLAGS_RESET;
            state.flags.acq_flags     <= `EVENT_FLAGS_RESET;
            state.flags.profile_flags <= `EVENT_FLAGS_RESET;
            state.flags.analog_flags  <= `EVENT_FLAGS_RESET;
        end else begin
            state <= next_state;
        end
    end

    // --------------------------------------------------------------
    // register port
    // --------------------------------------------------------------
    assign req.addr  = addr;
    assign req.wdata = wdata;
    assign req.wr    = wr;
    assign req.rd    = rd;

    event_reg_port u_port (
        .clock  (clock),
        .arst_n (arst_n),
        .req    (req),
        .flags  (state.flags),
        .rdata  (rdata)
    );

endmodule : loop_ch1_irq_status_bank

// >>> loop_ch1_status_properties.sv
`timescale 1ns/10ps

module loop_ch1_status_checker (
    input wire logic                             clock,
    input wire logic                             arst_n,
    input wire loop_ch1_event_pkg::loop_status_s status,
    input wire loop_ch1_event_pkg::loop_pulse_s  pulse,
    input wire logic [15:0]                      addr,
    input wire logic [7:0]                       wdata,
    input wire logic                             wr,
    input wire logic                             rd,
    input wire logic [7:0]                       rdata
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!arst_n);

    // ------------------------------------------------------------
    // read port
    // ------------------------------------------------------------
    property p_idle_zero; !$past(rd) |-> rdata == 8'h00; endproperty
    a_idle_zero: assert property (p_idle_zero) else $error("read data outside slot");
    property p_unmapped; rd && (addr < 16'h3015 || addr > 16'h3019) |=> rdata == 8'h00; endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    property p_state_rsvd; rd && addr == 16'h3016 |=> !rdata[1]; endproperty
    a_state_rsvd: assert property (p_state_rsvd) else $error("state spare bit set");
    property p_acq_rsvd;
        rd && addr == 16'h3017 |=> rdata[7:5] == 3'h0 && rdata[1:0] == 2'h0;
    endproperty
    a_acq_rsvd: assert property (p_acq_rsvd) else $error("acq spare bits set");
    property p_prof_rsvd; rd && addr == 16'h3018 |=> rdata[7:6] == 2'h0; endproperty
    a_prof_rsvd: assert property (p_prof_rsvd) else $error("profile spare bits set");
    property p_analog_rsvd; rd && addr == 16'h3019 |=> rdata[7:5] == 3'h0; endproperty
    a_analog_rsvd: assert property (p_analog_rsvd) else $error("analog spare bits set");

    // ------------------------------------------------------------
    // event capture
    // ------------------------------------------------------------
    // first edge after release only primes, hence the past reset term
    property p_freq_lock;
        $past(arst_n) && $rose(status.freq_locked) ##1 rd && addr == 16'h3015 |=> rdata[2];
    endproperty
    a_freq_lock: assert property (p_freq_lock) else $error("freq lock not flagged");
    property p_phase_unlock;
        $past(arst_n) && $fell(status.phase_locked) ##1 rd && addr == 16'h3015 |=> rdata[1];
    endproperty
    a_phase_unlock: assert property (p_phase_unlock) else $error("phase unlock lost");
    property p_history; pulse.history_update ##1 rd && addr == 16'h3016 |=> rdata[2]; endproperty
    a_history: assert property (p_history) else $error("history update lost");
    property p_dist_sync; pulse.dist_sync ##1 rd && addr == 16'h3019 |=> rdata[4]; endproperty
    a_dist_sync: assert property (p_dist_sync) else $error("distribution sync lost");

    c_lock_all: cover property (rd && addr == 16'h3015 ##1 rdata == 8'hFF);
    c_prof_all: cover property (rd && addr == 16'h3018 ##1 rdata == 8'h3F);
    c_write:    cover property (wr && addr == 16'h3017);
endmodule : loop_ch1_status_checker

bind loop_ch1_irq_status_bank loop_ch1_status_checker loop_ch1_status_checker_i (
    .clock(clock), .arst_n(arst_n), .status(status), .pulse(pulse), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata)
);

// >>> tb.sv
`timescale 1ns/10ps

module tb;
    logic                            clock;
    logic                            arst_n;
    loop_ch1_event_pkg::loop_status_s status;
    loop_ch1_event_pkg::loop_pulse_s  pulse;
    logic [15:0]                     addr;
    logic [7:0]                      wdata;
    logic                            wr;
    logic                            rd;
    logic [7:0]                      rdata;
    int                              err_total = 0;
    int                              n_checks  = 0;
    int                              cyc       = 0;
    logic [15:0]                     st;
    logic [7:0]                      d;
    logic [43:0]                     tab [0:30];
    logic [7:0]                      fin [0:4] = '{8'hFF, 8'hFD, 8'h1C, 8'h3F, 8'h1F};

    loop_ch1_irq_status_bank loop_ch1_irq_status_bank_i (
        .clock(clock), .arst_n(arst_n), .status(status), .pulse(pulse), .addr(addr),
        .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata)
    );

    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    // apply levels and pulses, then read one register at the next edge
    task automatic step(input logic [15:0] s, input logic [3:0] p, input logic [15:0] a,
                        output logic [7:0] v);
        @(posedge clock);
        status <= s;
        pulse  <= p;
        @(posedge clock);
        pulse  <= 4'h0;
        addr   <= a;
        rd     <= 1'b1;
        @(posedge clock);
        rd     <= 1'b0;
        #1 v = rdata;
    endtask : step

    task automatic wr_reg(input logic [15:0] a, input logic [7:0] v);
        @(posedge clock);
        addr  <= a;
        wdata <= v;
        wr    <= 1'b1;
        @(posedge clock);
        wr    <= 1'b0;
    endtask : wr_reg

    task automatic end_sim;
        $display("checks=%0d mismatches=%0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : end_sim

    always @(posedge clock) begin
        cyc++;
        if (cyc == 2000) begin
            err_total++;
            end_sim();
        end
    end

    // ------------------------------------------------------------
    // tests
    // ------------------------------------------------------------
    initial begin
        // {status, pulse, address, expected}; each row adds one event, except the profile 6 and 7 rows
        tab = '{
            {16'h8080, 4'h0, 16'h3015, 8'h04}, {16'hC080, 4'h0, 16'h3015, 8'h05},
            {16'hE080, 4'h0, 16'h3015, 8'h45}, {16'hF080, 4'h0, 16'h3015, 8'h55},
            {16'h7080, 4'h0, 16'h3015, 8'h5D}, {16'h3080, 4'h0, 16'h3015, 8'h5F},
            {16'h1080, 4'h0, 16'h3015, 8'hDF}, {16'h0080, 4'h0, 16'h3015, 8'hFF},
            {16'h0000, 4'h0, 16'h3016, 8'h40}, {16'h0040, 4'h0, 16'h3016, 8'h60},
            {16'h0050, 4'h0, 16'h3016, 8'hE0}, {16'h0850, 4'h0, 16'h3016, 8'hF0},
            {16'h0050, 4'h0, 16'h3016, 8'hF8}, {16'h0050, 4'h8, 16'h3016, 8'hFC},
            {16'h0050, 4'h4, 16'h3016, 8'hFD}, {16'h0050, 4'h2, 16'h3017, 8'h10},
            {16'h0450, 4'h0, 16'h3017, 8'h14}, {16'h0050, 4'h0, 16'h3017, 8'h1C},
            {16'h0058, 4'h0, 16'h3018, 8'h01}, {16'h0059, 4'h0, 16'h3018, 8'h03},
            {16'h005A, 4'h0, 16'h3018, 8'h07}, {16'h005B, 4'h0, 16'h3018, 8'h0F},
            {16'h005C, 4'h0, 16'h3018, 8'h1F}, {16'h005D, 4'h0, 16'h3018, 8'h3F},
            {16'h005E, 4'h0, 16'h3018, 8'h3F}, {16'h005F, 4'h0, 16'h3018, 8'h3F},
            {16'h005F, 4'h1, 16'h3019, 8'h10}, {16'h025F, 4'h0, 16'h3019, 8'h14},
            {16'h005F, 4'h0, 16'h3019, 8'h1C}, {16'h015F, 4'h0, 16'h3019, 8'h1D},
            {16'h005F, 4'h0, 16'h3019, 8'h1F}
        };
        st     = 16'h0080;
        status = st;
        pulse  = 4'h0;
        addr   = 16'h0000;
        wdata  = 8'h00;
        wr     = 1'b0;
        rd     = 1'b0;
        arst_n = 1'b0;
        repeat (2) @(posedge clock);
        arst_n <= 1'b1;
        for (int a = 32'h3014; a <= 32'h301A; a++) begin
            step(st, 4'h0, a[15:0], d);
            chk(d, 8'h00);
        end
        $display("test reset values done");
        for (int i = 0; i < 31; i++) begin
            st = tab[i][43:28];
            step(st, tab[i][27:24], tab[i][23:8], d);
            chk(d, tab[i][7:0]);
        end
        $display("test event capture done");
        for (int i = 0; i < 5; i++) begin
            wr_reg(16'h3015 + 16'(i), ~fin[i]);
            step(st, 4'h0, 16'h3015 + 16'(i), d);
            chk(d, fin[i]);
        end
        $display("test write ignore done");
        // second reset clears all; steady levels must not re-raise events
        // all levels but freerun and the profiles other than 5 held high across the reset, so priming is really exercised
        @(posedge clock);
        st     = 16'hFF5D;
        status <= st;
        arst_n <= 1'b0;
        repeat (2) @(posedge clock);
        arst_n <= 1'b1;
        for (int i = 0; i < 5; i++) begin
            step(st, 4'h0, 16'h3015 + 16'(i), d);
            chk(d, 8'h00);
        end
        $display("test mid-run reset done");
        end_sim();
    end
endmodule : tb
